// ### verilog/touch_host_defs.svh
// offsets, field positions, reset values and codes of the host control register bank
`ifndef TOUCH_HOST_DEFS_SVH
`define TOUCH_HOST_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HOST_CONTROL_OFFSET   8'h00
`define BUS_TARGET_OFFSET     8'h01

// ----------------------------------------------------------------
// host control fields
// ----------------------------------------------------------------
`define LOAD_DEFAULTS_BIT     5
`define CHECKSUM_MATCH_BIT    4
`define SAVE_FLASH_BIT        3
`define MODE_MSB              2
`define MODE_LSB              0
// mode wakes up in device configuration
`define MODE_RESET            3'h2

// ----------------------------------------------------------------
// bus target address
// ----------------------------------------------------------------
`define ADDR_MSB              6
`define ADDR_RESET            7'h37

// ----------------------------------------------------------------
// reserved locations read back this value
// ----------------------------------------------------------------
`define RESERVED_READ         8'h00

`endif

// ### verilog/touch_host_pkg.sv
// types shared by the host control register bank
package touch_host_pkg;

	typedef enum logic [2:0] {
		MODE_NORMAL     = 3'h0,
		MODE_LED_CFG    = 3'h1,
		MODE_DEV_CFG    = 3'h2,
		MODE_LINE_TEST  = 3'h3,
		MODE_DEBUG_DATA = 3'h4
	} dev_mode_t;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} host_access_t;

	typedef struct packed {
		logic loadDefaults;
		logic saveFlash;
	} op_request_t;

endpackage

// ### verilog/self_clearing_write_bit.sv
// one self-clearing command bit: set by a host write, cleared when the operation is done
`timescale 1ns/1ns
module self_clearing_write_bit (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic setReq,
	input  wire logic done,
	output logic      pending
);
	logic next_pending;

	// a new request in the same cycle as done wins, so it is never lost
	always_comb begin
		next_pending = pending;
		if (done)
			next_pending = 1'b0;
		if (setReq)
			next_pending = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			pending <= 1'b0;
		else
			pending <= next_pending;
	end
endmodule // self_clearing_write_bit

// ### verilog/touch_host_mode_config_regs.sv
// host control and bus target address registers of the touch controller
//
// Summary of operation
// - every register takes its documented power-up value on reset
// - reserved locations guarantee nothing; they read as zero here
// - writing one to bit 5 requests loading factory defaults into RAM
// - bit 4 reads one when host checksum equals computed checksum
// - writing one to bit 3 requests saving configuration into flash
// - load and save bits clear themselves once the operation completes
// - mode codes 000 normal, 001 LED config, 010 device config
// - mode 011 line test, 100 debug data; 101 to 111 invalid
// - bits 6:0 hold 7-bit target address, any value, reset 37h
`timescale 1ns/1ns
`include "touch_host_defs.svh"
module touch_host_mode_config_regs (
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire touch_host_pkg::host_access_t hostAccess,
	output logic [7:0]                       rdata,
	input  wire logic [15:0]                 hostChecksum,
	input  wire logic [15:0]                 calcChecksum,
	input  wire logic                        loadDone,
	input  wire logic                        saveDone,
	output touch_host_pkg::op_request_t      opRequest,
	output touch_host_pkg::dev_mode_t        devMode,
	output logic [6:0]                       targetAddress
);
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
		hits = (a == off);
	endfunction

	function automatic logic modeValid(input logic [2:0] m);
		modeValid = (m <= 3'(touch_host_pkg::MODE_DEBUG_DATA));
	endfunction

	logic wrHost;
	logic wrAddr;
	logic [2:0] wrMode;
	assign wrHost = hostAccess.write && hits(hostAccess.addr, `HOST_CONTROL_OFFSET);
	assign wrAddr = hostAccess.write && hits(hostAccess.addr, `BUS_TARGET_OFFSET);
	assign wrMode = hostAccess.wdata[`MODE_MSB:`MODE_LSB];

	// ----------------------------------------------------------------
	// command bits
	// ----------------------------------------------------------------
	// writing zero leaves a pending operation running
	self_clearing_write_bit u_load (
		.clk_sys (clk_sys),
		.rst     (rst),
		.setReq  (wrHost && hostAccess.wdata[`LOAD_DEFAULTS_BIT]),
		.done    (loadDone),
		.pending (opRequest.loadDefaults)
	);

	self_clearing_write_bit u_save (
		.clk_sys (clk_sys),
		.rst     (rst),
		.setReq  (wrHost && hostAccess.wdata[`SAVE_FLASH_BIT]),
		.done    (saveDone),
		.pending (opRequest.saveFlash)
	);

	// ----------------------------------------------------------------
	// mode, address, checksum and read data signals
	// ----------------------------------------------------------------
	touch_host_pkg::dev_mode_t next_devMode;
	logic [6:0]                next_targetAddress;
	logic                      checksumMatch;
	logic [7:0]                next_rdata;

	// ----------------------------------------------------------------
	// checksum status
	// ----------------------------------------------------------------
	// live compare, so the bit follows the latest host checksum
	assign checksumMatch = (hostChecksum == calcChecksum);

	// ----------------------------------------------------------------
	// mode and address next values
	// ----------------------------------------------------------------

	always_comb begin
		next_devMode = devMode;
		next_targetAddress = targetAddress;
		// invalid codes would leave the scanner undefined, so drop them
		if (wrHost && modeValid(wrMode))
			next_devMode = touch_host_pkg::dev_mode_t'(wrMode);
		if (wrAddr)
			next_targetAddress = hostAccess.wdata[`ADDR_MSB:0];
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			devMode <= touch_host_pkg::dev_mode_t'(`MODE_RESET);
			targetAddress <= `ADDR_RESET;
		end else begin
			devMode <= next_devMode;
			targetAddress <= next_targetAddress;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = rdata;
		if (hostAccess.read) begin
			next_rdata = `RESERVED_READ;
			if (hits(hostAccess.addr, `HOST_CONTROL_OFFSET)) begin
				next_rdata[`LOAD_DEFAULTS_BIT] = opRequest.loadDefaults;
				next_rdata[`CHECKSUM_MATCH_BIT] = checksumMatch;
				next_rdata[`SAVE_FLASH_BIT] = opRequest.saveFlash;
				next_rdata[`MODE_MSB:`MODE_LSB] = devMode;
			end else if (hits(hostAccess.addr, `BUS_TARGET_OFFSET)) begin
				next_rdata[`ADDR_MSB:0] = targetAddress;
			end
		end
	end

	// a read and a write in one cycle return the old value
	always_ff @(posedge clk_sys) begin
		if (rst)
			rdata <= `RESERVED_READ;
		else
			rdata <= next_rdata;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// read checks compare against the field constants; write checks reuse the wrHost, wrAddr and wrMode decode above
	chk_reset_values: assert property (@(posedge clk_sys)
		rst |=> (targetAddress == `ADDR_RESET && devMode == `MODE_RESET))
		else $error("reset values wrong");

	chk_reset_ops: assert property (@(posedge clk_sys)
		rst |=> (opRequest == '0 && rdata == `RESERVED_READ))
		else $error("reset left a request or read data");

	chk_load_request: assert property (@(posedge clk_sys) disable iff (rst)
		(wrHost && hostAccess.wdata[`LOAD_DEFAULTS_BIT]) |=> opRequest.loadDefaults)
		else $error("load request not raised");

	chk_load_zero: assert property (@(posedge clk_sys) disable iff (rst)
		(wrHost && !hostAccess.wdata[`LOAD_DEFAULTS_BIT] && !opRequest.loadDefaults)
		|=> !opRequest.loadDefaults)
		else $error("load raised by a zero write");

	chk_checksum_read: assert property (@(posedge clk_sys) disable iff (rst)
		(hostAccess.read && hostAccess.addr == `HOST_CONTROL_OFFSET)
		|=> (rdata[`CHECKSUM_MATCH_BIT] == $past(hostChecksum == calcChecksum)))
		else $error("checksum bit wrong");

	chk_save_request: assert property (@(posedge clk_sys) disable iff (rst)
		(wrHost && hostAccess.wdata[`SAVE_FLASH_BIT]) |=> opRequest.saveFlash)
		else $error("save request not raised");

	chk_save_zero: assert property (@(posedge clk_sys) disable iff (rst)
		(wrHost && !hostAccess.wdata[`SAVE_FLASH_BIT] && !opRequest.saveFlash)
		|=> !opRequest.saveFlash)
		else $error("save raised by a zero write");

	chk_self_clear: assert property (@(posedge clk_sys) disable iff (rst)
		(saveDone && !(wrHost && hostAccess.wdata[`SAVE_FLASH_BIT]))
		|=> !opRequest.saveFlash)
		else $error("save bit not cleared");

	chk_load_clear: assert property (@(posedge clk_sys) disable iff (rst)
		(loadDone && !(wrHost && hostAccess.wdata[`LOAD_DEFAULTS_BIT]))
		|=> !opRequest.loadDefaults)
		else $error("load bit not cleared");

	chk_save_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(opRequest.saveFlash && !saveDone) |=> opRequest.saveFlash)
		else $error("save bit dropped early");

	chk_load_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(opRequest.loadDefaults && !loadDone) |=> opRequest.loadDefaults)
		else $error("load bit dropped early");

	chk_ops_read: assert property (@(posedge clk_sys) disable iff (rst)
		(hostAccess.read && hostAccess.addr == `HOST_CONTROL_OFFSET)
		|=> (rdata[`LOAD_DEFAULTS_BIT] == $past(opRequest.loadDefaults)
			&& rdata[`SAVE_FLASH_BIT] == $past(opRequest.saveFlash)))
		else $error("pending bits read wrong");

	chk_mode_write: assert property (@(posedge clk_sys) disable iff (rst)
		(wrHost && wrMode <= 3'(touch_host_pkg::MODE_DEBUG_DATA))
		|=> (devMode == $past(wrMode)))
		else $error("mode not taken");

	chk_mode_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!wrHost |=> $stable(devMode))
		else $error("mode changed without a write");

	chk_mode_read: assert property (@(posedge clk_sys) disable iff (rst)
		(hostAccess.read && hostAccess.addr == `HOST_CONTROL_OFFSET)
		|=> (rdata[`MODE_MSB:`MODE_LSB] == $past(devMode)))
		else $error("mode read wrong");

	chk_mode_legal: assert property (@(posedge clk_sys) disable iff (rst)
		devMode <= touch_host_pkg::MODE_DEBUG_DATA)
		else $error("mode illegal");

	chk_mode_keep: assert property (@(posedge clk_sys) disable iff (rst)
		(wrHost && wrMode > 3'(touch_host_pkg::MODE_DEBUG_DATA)) |=> $stable(devMode))
		else $error("invalid mode accepted");

	chk_addr_write: assert property (@(posedge clk_sys) disable iff (rst)
		wrAddr |=> (targetAddress == $past(hostAccess.wdata[`ADDR_MSB:0])))
		else $error("address not stored");

	chk_addr_keep: assert property (@(posedge clk_sys) disable iff (rst)
		!wrAddr |=> $stable(targetAddress))
		else $error("address changed without a write");

	chk_addr_read: assert property (@(posedge clk_sys) disable iff (rst)
		(hostAccess.read && hostAccess.addr == `BUS_TARGET_OFFSET)
		|=> (rdata == {1'b0, $past(targetAddress)}))
		else $error("address read wrong");

	chk_reserved_read: assert property (@(posedge clk_sys) disable iff (rst)
		(hostAccess.read && hostAccess.addr != `HOST_CONTROL_OFFSET
			&& hostAccess.addr != `BUS_TARGET_OFFSET)
		|=> (rdata == `RESERVED_READ))
		else $error("reserved read not zero");
endmodule // touch_host_mode_config_regs

// ### verification/op_engine_model.sv
// behavioural model of the load and save engine behind the register bank
`timescale 1ns/1ns
module op_engine_model (
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic                        slow,
	input  wire touch_host_pkg::op_request_t opRequest,
	output logic                             loadDone,
	output logic                             saveDone
);
	logic [7:0] loadCnt;
	logic [7:0] saveCnt;
	logic [7:0] delay;
	assign delay = slow ? 8'h0c : 8'h01;
	always @(posedge clk_sys) begin
		loadCnt <= (rst || !opRequest.loadDefaults) ? 8'h00 : loadCnt + 8'h01;
		saveCnt <= (rst || !opRequest.saveFlash) ? 8'h00 : saveCnt + 8'h01;
	end
	// one done pulse per request; slow mimics a long flash program time
	assign loadDone = opRequest.loadDefaults && loadCnt == delay;
	assign saveDone = opRequest.saveFlash && saveCnt == delay;
endmodule // op_engine_model

// ### verification/touch_host_mode_config_regs_tb.sv
// self-checking bench for the host control register bank
`timescale 1ns/1ns
module touch_host_mode_config_regs_tb;
	logic                         clk_sys = 1'b0;
	logic                         rst = 1'b1;
	logic                         slow = 1'b0;
	touch_host_pkg::host_access_t hostAccess = '0;
	logic [15:0]                  hostChecksum = 16'h1234;
	logic [15:0]                  calcChecksum = 16'h4321;
	logic [7:0]                   rdata;
	logic                         loadDone;
	logic                         saveDone;
	touch_host_pkg::op_request_t  opRequest;
	touch_host_pkg::dev_mode_t    devMode;
	logic [6:0]                   targetAddress;
	int                           n_fail = 0;
	int                           check_count = 0;
	always #2 clk_sys = ~clk_sys;
	touch_host_mode_config_regs DUT (.clk_sys(clk_sys), .rst(rst), .hostAccess(hostAccess),
		.rdata(rdata), .hostChecksum(hostChecksum), .calcChecksum(calcChecksum),
		.loadDone(loadDone), .saveDone(saveDone), .opRequest(opRequest), .devMode(devMode),
		.targetAddress(targetAddress));
	op_engine_model FAR (.clk_sys(clk_sys), .rst(rst), .slow(slow), .opRequest(opRequest),
		.loadDone(loadDone), .saveDone(saveDone));
	// ------------------------------------------------
	// host access tasks
	// ------------------------------------------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		hostAccess = {1'b1, 1'b0, a, d};
		@(negedge clk_sys);
		hostAccess = '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		hostAccess = {1'b0, 1'b1, a, 8'h00};
		@(negedge clk_sys);
		hostAccess = '0;
		chk("rdata", e, rdata);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic t_reset;
		chk("devMode", 8'h02, {5'h00, devMode});
		chk("opRequest", 8'h00, {6'h00, opRequest});
		rd(8'h00, 8'h02);
		rd(8'h01, 8'h37);
	endtask
	task automatic t_modes;
		for (int m = 0; m < 8; m++) begin
			wr(8'h00, m[7:0]);
			chk("devMode", (m < 5) ? m[7:0] : 8'h04, {5'h00, devMode});
		end
		rd(8'h00, 8'h04);
	endtask
	task automatic t_addr;
		logic [7:0] v[3] = '{8'h00, 8'h7f, 8'h5a};
		foreach (v[i]) begin
			wr(8'h01, v[i]);
			chk("targetAddress", v[i], {1'b0, targetAddress});
			rd(8'h01, v[i]);
		end
	endtask
	task automatic t_sum;
		calcChecksum = 16'h1234;
		rd(8'h00, 8'h14);
		hostChecksum = 16'h1235;
		rd(8'h00, 8'h04);
	endtask
	// s stretches the engine so the pending bits can be read back
	task automatic op(input logic [7:0] d, input logic [1:0] r, input logic s, input logic [7:0] e);
		int i;
		slow = s;
		wr(8'h00, d);
		chk("opRequest", {6'h00, r}, {6'h00, opRequest});
		if (s)
			rd(8'h00, e | {2'b00, r[1], 1'b0, r[0], 3'b000});
		for (i = 0; i < 40 && opRequest !== 2'b00; i++)
			@(negedge clk_sys);
		if (i == 40) begin
			n_fail++;
			report_and_stop();
		end
		rd(8'h00, e);
	endtask
	// a reset in mid-run must drop a pending save and restore the power-up values
	task automatic t_rerun;
		slow = 1'b1;
		wr(8'h00, 8'h08);
		chk("opRequest", 8'h01, {6'h00, opRequest});
		@(negedge clk_sys);
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		chk("opRequest", 8'h00, {6'h00, opRequest});
		chk("devMode", 8'h02, {5'h00, devMode});
		chk("targetAddress", 8'h37, {1'b0, targetAddress});
		rd(8'h00, 8'h02);
	endtask
	initial begin
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		t_reset();
		t_modes();
		t_addr();
		t_sum();
		op(8'h20, 2'b10, 1'b0, 8'h00);
		op(8'h0a, 2'b01, 1'b1, 8'h02);
		op(8'h2f, 2'b11, 1'b1, 8'h02);
		op(8'h01, 2'b00, 1'b0, 8'h01);
		rd(8'h02, 8'h00);
		wr(8'h02, 8'hff);
		rd(8'h01, 8'h5a);
		rd(8'h00, 8'h01);
		t_rerun();
		report_and_stop();
	end
endmodule // touch_host_mode_config_regs_tb
